// file: verilog/sfc_buffer_ctrl.sv
// Sample buffer controller with APB register slave and interrupt
// Behaviour
// - 1536-byte store, three bytes per sample
// - Accept samples until 512 held
// - Level register reports unread stored samples
// - Interrupt when level reaches threshold
// - Control holds threshold bits, burst, clear
// - Threshold register holds low threshold bits
// - Double mode stores lit minus dark
module sfc_buffer_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [sfc_pkg::PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sample_valid,
	input wire logic [sfc_pkg::SAMPLE_W-1:0] sample_data,
	input wire logic emitter_lit_phase,
	output logic irq,
	output logic [sfc_pkg::BURST_W-1:0] burst_len
);
	typedef struct packed {
		logic [sfc_pkg::LVL_W-1:0] level;
		logic [sfc_pkg::PTR_W-1:0] wr_ptr;
		logic [sfc_pkg::PTR_W-1:0] rd_ptr;
		logic [1:0] byte_sel;
		logic [sfc_pkg::THR_W-1:0] thr;
		logic [sfc_pkg::BURST_W-1:0] burst;
		logic dbl;
		logic [sfc_pkg::ST_W-1:0] status;
		logic [sfc_pkg::ST_W-1:0] mask;
		logic irq;
		logic pready;
		logic pslverr;
		logic data_ok;
		logic [31:0] prdata;
	} sfc_state_t;

	sfc_state_t s_reg, s_next;

	logic push_valid;
	logic [sfc_pkg::SAMPLE_W-1:0] push_data;
	logic [sfc_pkg::SAMPLE_W-1:0] head;
	logic push_ok;
	logic pop;
	logic clr;
	logic thr_evt;
	logic wr_hs;
	logic rd_hs;

	// ***************************************
	// Intake and storage
	// ***************************************
	sfc_sample_diff u_diff (
		.pclk(pclk),
		.presetn(presetn),
		.sample_valid(sample_valid),
		.sample_data(sample_data),
		.emitter_lit_phase(emitter_lit_phase),
		.double_mode(s_reg.dbl),
		.push_valid(push_valid),
		.push_data(push_data)
	);

	sfc_sample_mem u_mem (
		.clk(pclk),
		.we(push_ok),
		.waddr(s_reg.wr_ptr),
		.wdata(push_data),
		.raddr(s_reg.rd_ptr),
		.rdata(head)
	);

	// ***************************************
	// Next state
	// ***************************************
	always_comb begin
		logic [7:0] idx;
		logic hit;
		logic [31:0] rd;
		logic [sfc_pkg::ST_W-1:0] set;
		idx = paddr[9:2];
		hit = 1'b0;
		rd = '0;
		set = '0;
		s_next = s_reg;
		wr_hs = psel && penable && s_reg.pready && pwrite;
		rd_hs = psel && penable && s_reg.pready && !pwrite;
		clr = wr_hs && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_CTRL)
			&& pstrb[0] && pwdata[sfc_pkg::CTRL_CLEAR_BIT];
		pop = 1'b0;

		// One wait state: read data and errors come from flops
		s_next.pready = psel && penable && !s_reg.pready;
		unique case (idx)
			sfc_pkg::IDX_CTRL: begin
				hit = 1'b1;
				rd[sfc_pkg::CTRL_BURST_LSB +: sfc_pkg::BURST_W] = s_reg.burst;
				rd[sfc_pkg::THR_W-sfc_pkg::THR_LO_W-1:0] =
					s_reg.thr[sfc_pkg::THR_W-1:sfc_pkg::THR_LO_W];
			end
			sfc_pkg::IDX_THRESH: begin
				hit = 1'b1;
				rd[sfc_pkg::THR_LO_W-1:0] = s_reg.thr[sfc_pkg::THR_LO_W-1:0];
			end
			sfc_pkg::IDX_LEVEL: begin
				hit = 1'b1;
				rd[sfc_pkg::LVL_W-1:0] = s_reg.level;
			end
			sfc_pkg::IDX_DATA: begin
				hit = 1'b1;
				if (s_reg.level != sfc_pkg::LVL_ZERO) begin
					rd[7:0] = head[(2 - s_reg.byte_sel) * 8 +: 8];
				end
			end
			sfc_pkg::IDX_STATUS: begin
				hit = 1'b1;
				rd[sfc_pkg::ST_W-1:0] = s_reg.status;
			end
			sfc_pkg::IDX_MASK: begin
				hit = 1'b1;
				rd[sfc_pkg::ST_W-1:0] = s_reg.mask;
			end
			sfc_pkg::IDX_MODE: begin
				hit = 1'b1;
				rd[sfc_pkg::MODE_DOUBLE_BIT] = s_reg.dbl;
			end
			default: hit = 1'b0;
		endcase
		hit = hit && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
		if (s_next.pready) begin
			// Refused addresses answer zero data along with the error
			s_next.prdata = (pwrite || !hit) ? '0 : rd;
			s_next.pslverr = !hit;
			s_next.data_ok = s_reg.level != sfc_pkg::LVL_ZERO;
		end else begin
			s_next.prdata = '0;
			s_next.pslverr = 1'b0;
		end

		// Register writes take effect only at the handshake edge
		if (wr_hs && pstrb[0]) begin
			unique case (paddr)
				sfc_pkg::reg_addr(sfc_pkg::IDX_CTRL): begin
					s_next.thr[sfc_pkg::THR_W-1:sfc_pkg::THR_LO_W] =
						pwdata[sfc_pkg::THR_W-sfc_pkg::THR_LO_W-1:0];
					s_next.burst =
						pwdata[sfc_pkg::CTRL_BURST_LSB +: sfc_pkg::BURST_W];
				end
				sfc_pkg::reg_addr(sfc_pkg::IDX_THRESH): begin
					s_next.thr[sfc_pkg::THR_LO_W-1:0] =
						pwdata[sfc_pkg::THR_LO_W-1:0];
				end
				sfc_pkg::reg_addr(sfc_pkg::IDX_STATUS): begin
					s_next.status = s_reg.status & ~pwdata[sfc_pkg::ST_W-1:0];
				end
				sfc_pkg::reg_addr(sfc_pkg::IDX_MASK): begin
					s_next.mask = pwdata[sfc_pkg::ST_W-1:0];
				end
				sfc_pkg::reg_addr(sfc_pkg::IDX_MODE): begin
					s_next.dbl = pwdata[sfc_pkg::MODE_DOUBLE_BIT];
				end
				default: s_next.dbl = s_reg.dbl;
			endcase
		end

		// three byte reads retire one sample
		if (rd_hs && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_DATA)) begin
			if (!s_reg.data_ok) begin
				set[sfc_pkg::ST_UDF] = 1'b1;
			end else if (s_reg.byte_sel == sfc_pkg::BYTE_LAST) begin
				pop = 1'b1;
				s_next.byte_sel = sfc_pkg::BYTE_FIRST;
				s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
			end else begin
				s_next.byte_sel = s_reg.byte_sel + 1'b1;
			end
		end

		// refuse when 512 held, flag overflow
		push_ok = push_valid && !clr && s_reg.level != sfc_pkg::LVL_FULL;
		if (push_valid && !clr && !push_ok) begin
			set[sfc_pkg::ST_OVF] = 1'b1;
		end
		if (push_ok) begin
			s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
		end

		if (push_ok && !pop) begin
			s_next.level = s_reg.level + sfc_pkg::LVL_ONE;
		end else if (pop && !push_ok) begin
			s_next.level = s_reg.level - sfc_pkg::LVL_ONE;
		end

		// clear empties the store; wins over push
		if (clr) begin
			s_next.level = sfc_pkg::LVL_ZERO;
			s_next.wr_ptr = '0;
			s_next.rd_ptr = '0;
			s_next.byte_sel = sfc_pkg::BYTE_FIRST;
		end

		// event on rising to the threshold
		thr_evt = push_ok && !pop && s_next.level == s_reg.thr;
		set[sfc_pkg::ST_THR] = thr_evt;

		// Set wins over a same-cycle write-one clear
		s_next.status = s_next.status | set;
		s_next.irq = |(s_next.status & s_next.mask);
	end

	// ***************************************
	// State register
	// ***************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{thr: sfc_pkg::THR_RESET, burst: sfc_pkg::BURST_RESET,
				mask: sfc_pkg::MASK_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign irq = s_reg.irq;
	assign burst_len = s_reg.burst;

	// ***************************************
	// Checks
	// ***************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	level_bound_a: assert property (
		s_reg.level <= sfc_pkg::LVL_FULL)
		else $error("level above capacity");
	full_refuse_a: assert property (
		push_valid && !clr && !pop && s_reg.level == sfc_pkg::LVL_FULL
		|=> s_reg.level == sfc_pkg::LVL_FULL && s_reg.status[sfc_pkg::ST_OVF])
		else $error("push into full store not refused");
	level_push_a: assert property (
		push_ok && !pop && !clr
		|=> s_reg.level == $past(s_reg.level) + sfc_pkg::LVL_ONE)
		else $error("level did not count a push");
	level_pop_a: assert property (
		pop && !push_ok && !clr
		|=> s_reg.level == $past(s_reg.level) - sfc_pkg::LVL_ONE)
		else $error("level did not count a pop");
	thr_irq_a: assert property (
		thr_evt && s_reg.mask[sfc_pkg::ST_THR] |=> irq ##1 irq)
		else $error("threshold did not raise interrupt");
	irq_mask_a: assert property (
		irq == |(s_reg.status & s_reg.mask))
		else $error("interrupt disagrees with status and mask");
	clear_flush_a: assert property (
		clr |=> s_reg.level == sfc_pkg::LVL_ZERO
			&& s_reg.byte_sel == sfc_pkg::BYTE_FIRST)
		else $error("clear did not empty the store");
	thr_write_a: assert property (
		wr_hs && pstrb[0] && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_THRESH)
		|=> s_reg.thr[sfc_pkg::THR_LO_W-1:0]
			== $past(pwdata[sfc_pkg::THR_LO_W-1:0]))
		else $error("threshold write lost");
	pop_third_a: assert property (
		pop |-> s_reg.byte_sel == sfc_pkg::BYTE_LAST && s_reg.data_ok)
		else $error("sample retired before third byte");
	apb_answer_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("slave answer not one wait state");
	udf_refuse_a: assert property (
		rd_hs && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_DATA)
			&& !s_reg.data_ok && !push_ok
		|=> s_reg.status[sfc_pkg::ST_UDF]
			&& s_reg.level == $past(s_reg.level))
		else $error("empty data read not refused");
	thr_reach_a: assert property (
		push_ok && !pop
			&& s_reg.level + sfc_pkg::LVL_ONE == s_reg.thr
		|=> s_reg.status[sfc_pkg::ST_THR])
		else $error("threshold reach not flagged");
	burst_write_a: assert property (
		wr_hs && pstrb[0] && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_CTRL)
		|=> burst_len
			== $past(pwdata[sfc_pkg::CTRL_BURST_LSB +: sfc_pkg::BURST_W]))
		else $error("burst length write lost");
	mode_write_a: assert property (
		wr_hs && pstrb[0] && paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_MODE)
		|=> s_reg.dbl == $past(pwdata[sfc_pkg::MODE_DOUBLE_BIT]))
		else $error("double mode write lost");
	data_byte_a: assert property (
		psel && penable && !pready && !pwrite
			&& paddr == sfc_pkg::reg_addr(sfc_pkg::IDX_DATA)
			&& s_reg.level != sfc_pkg::LVL_ZERO
			&& s_reg.byte_sel == sfc_pkg::BYTE_FIRST
		|=> prdata[7:0] == $past(head[sfc_pkg::SAMPLE_W-1 -: 8]))
		else $error("data port did not lead with top byte");
	bad_addr_a: assert property (
		psel && penable && !pready && !pwrite
			&& (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
		|=> pslverr && prdata == '0)
		else $error("refused address not answered with error");
	idle_zero_a: assert property (
		!pready |-> prdata == '0 && !pslverr)
		else $error("answer outside the ready cycle");

	// ***************************************
	// Coverage
	// ***************************************
	full_c: cover property (s_reg.level == sfc_pkg::LVL_FULL);
	irq_c: cover property (thr_evt ##[1:4] irq);
	pop_c: cover property (pop);
	clear_c: cover property (clr && s_reg.level != sfc_pkg::LVL_ZERO);
	dbl_c: cover property (s_reg.dbl && push_valid);
endmodule : sfc_buffer_ctrl

// file: verilog/sfc_pkg.sv
// Shared constants of the sample buffer block
package sfc_pkg;

	// ***************************************
	// Storage geometry
	// ***************************************
	localparam int SAMPLE_W = 24;
	localparam int BYTES_PER_SAMPLE = 3;
	localparam int CAPACITY_BYTES = 1536;
	localparam int DEPTH = CAPACITY_BYTES / BYTES_PER_SAMPLE;
	localparam int PTR_W = $clog2(DEPTH);
	localparam int LVL_W = PTR_W + 1;
	localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(DEPTH);
	localparam logic [LVL_W-1:0] LVL_ZERO = '0;
	localparam logic [LVL_W-1:0] LVL_ONE = LVL_W'(1);
	localparam logic [1:0] BYTE_FIRST = 2'h0;
	localparam logic [1:0] BYTE_LAST = 2'h2;

	// ***************************************
	// Register map: printed indices, byte address is index times four
	// ***************************************
	localparam int PADDR_W = 12;
	localparam logic [7:0] IDX_CTRL = 8'h75;
	localparam logic [7:0] IDX_THRESH = 8'h76;
	localparam logic [7:0] IDX_LEVEL = 8'h77;
	localparam logic [7:0] IDX_DATA = 8'h78;
	localparam logic [7:0] IDX_STATUS = 8'h79;
	localparam logic [7:0] IDX_MASK = 8'h7A;
	localparam logic [7:0] IDX_MODE = 8'h7B;

	// ***************************************
	// Field layout and reset values
	// ***************************************
	localparam int THR_W = 10;
	localparam int THR_LO_W = 8;
	localparam int BURST_W = 3;
	localparam int CTRL_BURST_LSB = 2;
	localparam int CTRL_CLEAR_BIT = 7;
	localparam int ST_W = 3;
	localparam int ST_THR = 0;
	localparam int ST_OVF = 1;
	localparam int ST_UDF = 2;
	localparam int MODE_DOUBLE_BIT = 0;
	localparam logic [THR_W-1:0] THR_RESET = 10'h000;
	localparam logic [BURST_W-1:0] BURST_RESET = 3'h0;
	localparam logic [ST_W-1:0] MASK_RESET = 3'h0;

	function automatic logic [PADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'h0, idx, 2'h0};
	endfunction : reg_addr

endpackage : sfc_pkg

// file: verilog/sfc_sample_mem.sv
// Sample storage array with registered read data
module sfc_sample_mem #(
	parameter int WIDTH = sfc_pkg::SAMPLE_W,
	parameter int DEPTH = sfc_pkg::DEPTH,
	parameter int AW = sfc_pkg::PTR_W
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Write-through on a same-address write: a sample pushed into an empty
	// store is readable in the very next bus access cycle
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (we && waddr == raddr) begin
			rdata <= wdata;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : sfc_sample_mem

// file: verilog/sfc_sample_diff.sv
// Converter sample intake with ambient subtraction in double mode
module sfc_sample_diff (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic sample_valid,
	input wire logic [sfc_pkg::SAMPLE_W-1:0] sample_data,
	input wire logic emitter_lit_phase,
	input wire logic double_mode,
	output logic push_valid,
	output logic [sfc_pkg::SAMPLE_W-1:0] push_data
);
	typedef struct packed {
		logic held;
		logic [sfc_pkg::SAMPLE_W-1:0] lit;
		logic push;
		logic [sfc_pkg::SAMPLE_W-1:0] data;
	} sfc_diff_t;

	sfc_diff_t s_reg, s_next;

	always_comb begin
		s_next = s_reg;
		s_next.push = 1'b0;
		if (!double_mode) begin
			s_next.held = 1'b0;
			if (sample_valid && emitter_lit_phase) begin
				s_next.push = 1'b1;
				s_next.data = sample_data;
			end
		end else if (sample_valid && emitter_lit_phase) begin
			s_next.held = 1'b1;
			s_next.lit = sample_data;
		end else if (sample_valid && s_reg.held) begin
			s_next.held = 1'b0;
			s_next.push = 1'b1;
			s_next.data = s_reg.lit - sample_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign push_valid = s_reg.push;
	assign push_data = s_reg.data;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	diff_push_a: assert property (
		double_mode && sample_valid && !emitter_lit_phase && s_reg.held
		|=> push_valid && push_data == $past(s_reg.lit) - $past(sample_data))
		else $error("double mode difference not pushed");
	dark_only_a: assert property (
		double_mode && sample_valid && emitter_lit_phase |=> !push_valid)
		else $error("lit sample pushed in double mode");
endmodule : sfc_sample_diff

// file: bench/sfc_host_model.sv
// Host model: APB master that notes each expected read answer
module sfc_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [sfc_pkg::PADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic pready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************
	// Bus cycles
	// ***************************************
	logic [32:0] q[$];
	logic tmo = 1'b0;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
	end

	// Request held until pready is sampled high or 50 clock edges pass
	task automatic xfer(input logic w, input logic [sfc_pkg::PADDR_W-1:0] a,
		input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) tmo <= 1'b1;
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(1'b1, sfc_pkg::reg_addr(idx), d, 33'h0);
	endtask : wr

	// read of any register index, answer noted as expected data with no error
	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		xfer(1'b0, sfc_pkg::reg_addr(idx), 32'h0, {1'b0, e});
	endtask : rd
endmodule : sfc_host_model

// file: bench/sample_fifo_control_tb_top.sv
// Testbench of the sample buffer controller
module sample_fifo_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ***************************************
	// Signals and instances
	// ***************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic sv = 1'b0;
	logic lit = 1'b0;
	logic [23:0] sd = '0;
	logic psel, penable, pwrite, pready, pslverr, irq;
	logic [sfc_pkg::PADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [2:0] burst_len;
	logic [32:0] exp;
	logic [23:0] d0, a, b;
	int error_cnt = 0;
	int n_compared = 0;
	int seed = 90612;

	always #5 pclk = ~pclk;

	sfc_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready));

	sfc_buffer_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sample_valid(sv), .sample_data(sd),
		.emitter_lit_phase(lit), .irq(irq), .burst_len(burst_len));

	// ***************************************
	// Checking
	// ***************************************
	task automatic test_done;
		if (error_cnt == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	task automatic chk(input string s, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	// Oldest note against each read answer, error flag included
	always @(posedge pclk) begin
		if (host.tmo) begin
			error_cnt++;
			$display("FAIL pready expected 1 seen 0");
			test_done();
		end else if (psel && penable && pready === 1'b1 && !pwrite) begin
			exp = host.q.pop_front();
			n_compared++;
			if ({pslverr, prdata} !== exp) begin
				error_cnt++;
				$display("FAIL read %h expected %h seen %h", paddr, exp,
					{pslverr, prdata});
			end
		end
	end

	task automatic smp(input logic l, input logic [23:0] d);
		@(posedge pclk);
		sv <= 1'b1;
		lit <= l;
		sd <= d;
		@(posedge pclk);
		sv <= 1'b0;
	endtask : smp

	// ***************************************
	// Scenarios
	// ***************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		host.rd(8'h75, 32'h0);
		host.rd(8'h76, 32'h0);
		host.rd(8'h77, 32'h0);
		host.rd(8'h7A, 32'h0);
		host.xfer(1'b0, 12'h1FC, 32'h0, {1'b1, 32'h0});
		host.wr(8'h75, 32'h15);
		host.wr(8'h76, 32'hFF);
		host.wr(8'h7A, 32'h1);
		host.rd(8'h75, 32'h15);
		host.rd(8'h76, 32'hFF);
		host.xfer(1'b0, 12'h1D5, 32'h0, {1'b1, 32'h0});
		host.xfer(1'b0, 12'h5D4, 32'h0, {1'b1, 32'h0});
		chk("burst_len", 32'h5, 32'(burst_len));
		// Back-to-back lit samples, one past full; threshold 0x1FF
		d0 = 24'($random(seed));
		@(posedge pclk);
		sv <= 1'b1;
		lit <= 1'b1;
		sd <= d0;
		repeat (513) @(posedge pclk) sd <= 24'($random(seed));
		sv <= 1'b0;
		repeat (3) @(posedge pclk);
		host.rd(8'h77, 32'h200);
		host.rd(8'h79, 32'h3);
		chk("irq", 32'h1, 32'(irq));
		host.rd(8'h78, 32'(d0[23:16]));
		host.rd(8'h78, 32'(d0[15:8]));
		host.rd(8'h78, 32'(d0[7:0]));
		host.rd(8'h77, 32'h1FF);
		host.wr(8'h79, 32'h1);
		host.rd(8'h79, 32'h2);
		chk("irq", 32'h0, 32'(irq));
		host.wr(8'h75, 32'h95);
		host.rd(8'h77, 32'h0);
		host.rd(8'h78, 32'h0);
		host.rd(8'h79, 32'h6);
		// Double mode: lit minus dark, lone dark ignored
		host.wr(8'h7B, 32'h1);
		a = 24'($random(seed));
		b = 24'($random(seed));
		smp(1'b1, a);
		smp(1'b0, b);
		smp(1'b0, a);
		repeat (3) @(posedge pclk);
		host.rd(8'h77, 32'h1);
		a = a - b;
		host.rd(8'h78, 32'(a[23:16]));
		host.rd(8'h78, 32'(a[15:8]));
		host.rd(8'h78, 32'(a[7:0]));
		host.wr(8'h7B, 32'h0);
		smp(1'b0, b);
		repeat (3) @(posedge pclk);
		host.rd(8'h77, 32'h0);
		test_done();
	end
endmodule : sample_fifo_control_tb_top
